// ==== rtl/sgp_gpio.sv ====
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sgp_defs.svh"

module sgp_gpio (
    input  wire logic                  pclk,          // block clock, 250 MHz
    input  wire logic                  presetn,       // async reset, active low
    input  wire logic                  psel,          // apb select
    input  wire logic                  penable,       // apb access phase
    input  wire logic                  pwrite,        // apb direction
    input  wire logic [`SGP_AW-1:0]    paddr,         // apb byte address
    input  wire logic [`SGP_DW-1:0]    pwdata,        // apb write data
    output var  logic [`SGP_DW-1:0]    prdata,        // apb read data
    output var  logic                  pready,        // apb ready
    output var  logic                  pslverr,       // apb error
    input  wire logic [`SGP_NPINS-1:0] aux_pins_in,   // pin levels
    output var  logic [`SGP_NPINS-1:0] aux_pins_out,  // pin drive values
    output var  logic [`SGP_NPINS-1:0] aux_pins_oe_n, // low drives pin
    output var  logic                  irq            // level interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic sgp_pkg::sgp_reg_type sgp_decode(
        input logic [`SGP_AW-1:0] addr
    );
        sgp_pkg::sgp_reg_type sel;
        sel = sgp_pkg::sgp_reg_none;
        case ({addr[`SGP_AW-1:2], 2'b00})
            `SGP_OFF_DIR: sel = sgp_pkg::sgp_reg_dir;
            `SGP_OFF_OUT: sel = sgp_pkg::sgp_reg_out;
            `SGP_OFF_PIN: sel = sgp_pkg::sgp_reg_pin;
            `SGP_OFF_IEN: sel = sgp_pkg::sgp_reg_ien;
            `SGP_OFF_ENA: sel = sgp_pkg::sgp_reg_ena;
            `SGP_OFF_STS: sel = sgp_pkg::sgp_reg_sts;
            `SGP_OFF_CLR: sel = sgp_pkg::sgp_reg_clr;
            // reserved word answers with an error like any hole
            default:      sel = sgp_pkg::sgp_reg_none;
        endcase
        return sel;
    endfunction

    sgp_pkg::sgp_reg_type sel;
    logic                 acc;
    logic                 wr;
    logic                 rd_setup;
    logic                 rd_pin;

    assign sel      = sgp_decode(paddr);
    assign acc      = psel & penable;
    assign wr       = acc & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign rd_pin   = acc & ~pwrite & (sel == sgp_pkg::sgp_reg_pin);

    // zero wait states: read data is caught in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = acc & (sel == sgp_pkg::sgp_reg_none);

    ////////////////////////////////////////////////////////////////////////
    // enable register: clock enable and hold reset, on presetn only

    logic [1:0] ena;
    logic [1:0] next_ena;
    logic       ce;
    logic       hold;
    logic       run;

    assign ce   = ena[`SGP_ENA_CE];
    assign hold = ena[`SGP_ENA_MR];
    assign run  = ce & ~hold;

    always_comb begin
        next_ena = ena;
        if (wr && sel == sgp_pkg::sgp_reg_ena) begin
            // reserved bits above are dropped
            next_ena = pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ena <= `SGP_ENA_RST;
        end else begin
            ena <= next_ena;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin input synchroniser and change detector

    sgp_pin_if pif ();

    assign pif.pins_in = aux_pins_in;
    assign pif.run     = run;
    assign pif.hold    = hold;

    sgp_pin_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pif     (pif)
    );

    ////////////////////////////////////////////////////////////////////////
    // block registers: held in reset by the hold bit, frozen without ce

    logic [`SGP_NPINS-1:0] dir;
    logic [`SGP_NPINS-1:0] next_dir;
    logic [`SGP_NPINS-1:0] out_mask;
    logic [`SGP_NPINS-1:0] next_out_mask;
    logic [`SGP_NPINS-1:0] out_data;
    logic [`SGP_NPINS-1:0] next_out_data;
    logic [`SGP_NIRQ-1:0]  ien;
    logic [`SGP_NIRQ-1:0]  next_ien;
    logic [`SGP_NPINS-1:0] wr_mask;
    logic [`SGP_NPINS-1:0] wr_data;

    assign wr_mask = pwdata[`SGP_DW-1:`SGP_MASK_LSB];
    assign wr_data = pwdata[`SGP_NPINS-1:0];

    always_comb begin
        next_dir      = dir;
        next_out_mask = out_mask;
        next_out_data = out_data;
        next_ien      = ien;
        if (hold) begin
            next_dir      = `SGP_DIR_RST;
            next_out_mask = `SGP_DATA_RST;
            next_out_data = `SGP_DATA_RST;
            next_ien      = `SGP_IEN_RST;
        end else if (run && wr) begin
            case (sel)
                sgp_pkg::sgp_reg_dir: begin
                    // direction alone, data untouched
                    next_dir = wr_data;
                end
                sgp_pkg::sgp_reg_out: begin
                    next_out_mask = wr_mask;
                    next_out_data = (out_data & ~wr_mask)
                                  | (wr_data & wr_mask);
                end
                sgp_pkg::sgp_reg_ien: begin
                    next_ien = pwdata[`SGP_NIRQ-1:0];
                end
                default: begin
                    next_dir = dir;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir      <= `SGP_DIR_RST;
            out_mask <= `SGP_DATA_RST;
            out_data <= `SGP_DATA_RST;
            ien      <= `SGP_IEN_RST;
        end else begin
            dir      <= next_dir;
            out_mask <= next_out_mask;
            out_data <= next_out_data;
            ien      <= next_ien;
        end
    end

    // driver enable only; data pins always carry out_data
    assign aux_pins_out  = out_data;
    assign aux_pins_oe_n = ~dir;

    ////////////////////////////////////////////////////////////////////////
    // interrupt status: sticky, set wins over clear

    logic [`SGP_NIRQ-1:0] sts;
    logic [`SGP_NIRQ-1:0] next_sts;
    logic [`SGP_NIRQ-1:0] sts_clr;
    logic                 next_irq;

    always_comb begin
        sts_clr = '0;
        if (wr && sel == sgp_pkg::sgp_reg_clr) begin
            sts_clr = pwdata[`SGP_NIRQ-1:0];
        end
        if (rd_pin) begin
            sts_clr = '1;
        end
    end

    always_comb begin
        next_sts = sts;
        if (hold) begin
            next_sts = `SGP_STS_RST;
        end else if (run) begin
            next_sts = (sts & ~sts_clr) | pif.change;
        end else begin
            next_sts = sts & ~sts_clr;
        end
        next_irq = |(next_sts & next_ien);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts <= `SGP_STS_RST;
            irq <= 1'b0;
        end else begin
            sts <= next_sts;
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, registered in the setup cycle

    logic [`SGP_DW-1:0] next_prdata;

    always_comb begin
        next_prdata = prdata;
        if (rd_setup) begin
            next_prdata = `SGP_ZERO32;
            case (sel)
                sgp_pkg::sgp_reg_dir: begin
                    next_prdata[`SGP_NPINS-1:0] = dir;
                end
                sgp_pkg::sgp_reg_out: begin
                    next_prdata = {out_mask, out_data};
                end
                sgp_pkg::sgp_reg_pin: begin
                    // upper half stays zero
                    next_prdata[`SGP_NPINS-1:0] = pif.level;
                end
                sgp_pkg::sgp_reg_ien: begin
                    next_prdata[`SGP_NIRQ-1:0] = ien;
                end
                sgp_pkg::sgp_reg_ena: begin
                    next_prdata[1:0] = ena;
                end
                sgp_pkg::sgp_reg_sts: begin
                    next_prdata[`SGP_NIRQ-1:0] = sts;
                end
                default: begin
                    next_prdata = `SGP_ZERO32;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `SGP_ZERO32;
        end else begin
            prdata <= next_prdata;
        end
    end

endmodule

`default_nettype wire

// ==== rtl/sgp_defs.svh ====
`ifndef SGP_DEFS_SVH
`define SGP_DEFS_SVH

`define SGP_NPINS     16
`define SGP_NIRQ      8
`define SGP_IRQ_LO    8
`define SGP_WARM_CYC  3
`define SGP_AW        8
`define SGP_DW        32

`define SGP_OFF_DIR   8'h00
`define SGP_OFF_RSV   8'h04
`define SGP_OFF_OUT   8'h08
`define SGP_OFF_PIN   8'h0C
`define SGP_OFF_IEN   8'h10
`define SGP_OFF_ENA   8'h14
`define SGP_OFF_STS   8'h18
`define SGP_OFF_CLR   8'h1C

`define SGP_MASK_LSB  16
`define SGP_ENA_CE    0
`define SGP_ENA_MR    1

`define SGP_DIR_RST   16'h0000
`define SGP_DATA_RST  16'h0000
`define SGP_IEN_RST   8'h00
`define SGP_STS_RST   8'h00
`define SGP_ENA_RST   2'h2
`define SGP_ZERO32    32'h0000_0000

`endif

// ==== rtl/sgp_pkg.sv ====
package sgp_pkg;

    typedef enum logic [2:0] {
        sgp_reg_dir,
        sgp_reg_out,
        sgp_reg_pin,
        sgp_reg_ien,
        sgp_reg_ena,
        sgp_reg_sts,
        sgp_reg_clr,
        sgp_reg_none
    } sgp_reg_type;

endpackage

// ==== rtl/sgp_pin_if.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sgp_defs.svh"

interface sgp_pin_if;
    logic [`SGP_NPINS-1:0] pins_in;
    logic                  run;
    logic                  hold;
    logic [`SGP_NPINS-1:0] level;
    logic [`SGP_NIRQ-1:0]  change;

    modport sync (input pins_in, input run, input hold, output level, output change);
    modport core (output pins_in, output run, output hold, input level, input change);
endinterface

`default_nettype wire

// ==== rtl/sgp_pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sgp_defs.svh"

module sgp_pin_sync (
    input  wire logic pclk,    // block clock
    input  wire logic presetn, // async reset, active low
    sgp_pin_if.sync   pif      // pins in, levels and changes out
);

    logic [`SGP_WARM_CYC-1:0] warm;
    logic [`SGP_WARM_CYC-1:0] next_warm;
    logic [`SGP_NIRQ-1:0]     prev;
    logic [`SGP_NIRQ-1:0]     next_prev;

    ////////////////////////////////////////////////////////////////////////
    genvar i;
    for (i = 0; i < `SGP_NPINS; i++) begin : g_pin
        logic meta;
        logic sync;
        logic held;
        logic next_meta;
        logic next_sync;
        logic next_held;

        // the two flops run free: gating ahead of them would put logic on the raw pin
        always_comb begin
            next_meta = pif.pins_in[i];
            next_sync = meta;
            next_held = held;
            if (pif.hold) begin
                next_held = 1'b0;
            end else if (pif.run) begin
                next_held = sync;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta <= 1'b0;
                sync <= 1'b0;
                held <= 1'b0;
            end else begin
                meta <= next_meta;
                sync <= next_sync;
                held <= next_held;
            end
        end

        assign pif.level[i] = held;
    end

    ////////////////////////////////////////////////////////////////////////
    // edges are ignored until the pipe holds real samples, else the
    // flush under hold would look like a change on release
    always_comb begin
        next_warm = warm;
        next_prev = prev;
        if (pif.hold) begin
            next_warm = '0;
            next_prev = '0;
        end else if (pif.run) begin
            next_warm = {warm[`SGP_WARM_CYC-2:0], 1'b1};
            next_prev = pif.level[`SGP_NPINS-1:`SGP_IRQ_LO];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warm <= '0;
            prev <= '0;
        end else begin
            warm <= next_warm;
            prev <= next_prev;
        end
    end

    for (i = 0; i < `SGP_NIRQ; i++) begin : g_edge
        assign pif.change[i] = pif.run & warm[`SGP_WARM_CYC-1]
                             & (pif.level[`SGP_IRQ_LO+i] ^ prev[i]);
    end

endmodule

`default_nettype wire

// ==== sim/sgp_gpio_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module sgp_gpio_properties (
    input wire logic        pclk,          // clock
    input wire logic        presetn,       // reset
    input wire logic        psel,          // select
    input wire logic        penable,       // access
    input wire logic        pwrite,        // write
    input wire logic [7:0]  paddr,         // address
    input wire logic [31:0] pwdata,        // wdata
    input wire logic [31:0] prdata,        // rdata
    input wire logic        pready,        // ready
    input wire logic        pslverr,       // error
    input wire logic [15:0] aux_pins_in,   // levels
    input wire logic [15:0] aux_pins_out,  // drive
    input wire logic [15:0] aux_pins_oe_n, // enables
    input wire logic        irq            // interrupt
);
    logic [1:0]  ena_q, next_ena_q;
    logic [7:0]  ien_q, next_ien_q;
    logic [15:0] prev_in, next_prev_in;
    logic [3:0]  stab, next_stab, run_n, next_run_n;
    logic        acc, run;
    assign acc = psel && penable;
    assign run = ena_q == 2'h1;
    // shadows of enable registers, the checker cannot see inside
    always_comb begin
        next_ena_q = (acc && pwrite && paddr == 8'h14) ? pwdata[1:0] : ena_q;
        next_ien_q = (acc && pwrite && run && paddr == 8'h10) ? pwdata[7:0] : ien_q;
        if (ena_q[1]) next_ien_q = 8'h00;
        next_prev_in = aux_pins_in;
        next_stab = (aux_pins_in != prev_in) ? 4'h0 : stab + {3'h0, stab != 4'hf};
        next_run_n = run ? run_n + {3'h0, run_n != 4'hf} : 4'h0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            {ena_q, ien_q, prev_in, stab, run_n} <= {2'h2, 8'h00, 16'h0000, 4'h0, 4'h0};
        else
            {ena_q, ien_q, prev_in, stab, run_n} <= {next_ena_q, next_ien_q, next_prev_in, next_stab, next_run_n};
    end
    ////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence sq_wr(logic [7:0] a);
        acc && pwrite && run && paddr == a;
    endsequence
    sequence sq_edge;
        run_n > 4'h8 && ((aux_pins_in[15:8] ^ prev_in[15:8]) & ien_q) != 8'h00;
    endsequence
    // stable pins only: a fresh edge may still be in the synchroniser
    sequence sq_pin_rd;
        acc && !pwrite && paddr == 8'h0c && run_n > 4'h4 && stab > 4'h4;
    endsequence
    a_dir_drive: assert property (sq_wr(8'h00) |=> aux_pins_oe_n == ~$past(pwdata[15:0]))
        else $error("pin enable not from direction write");
    a_out_mask: assert property (sq_wr(8'h08) |=> aux_pins_out ==
        (($past(pwdata[15:0]) & $past(pwdata[31:16])) | ($past(aux_pins_out) & ~$past(pwdata[31:16]))))
        else $error("masked output write wrong");
    a_hold_clear: assert property (ena_q[1] && !(acc && pwrite && paddr == 8'h14) |=>
        aux_pins_oe_n == 16'hffff && aux_pins_out == 16'h0000 && !irq) else $error("held block not cleared");
    a_ce_freeze: assert property (ena_q == 2'h0 |=> $stable(aux_pins_out) && $stable(aux_pins_oe_n))
        else $error("frozen block changed pins");
    a_rst_idle: assert property ($rose(presetn) |-> aux_pins_oe_n == 16'hffff && !irq)
        else $error("pins driven after reset");
    a_pin_rsvd: assert property (acc && !pwrite && paddr == 8'h0c |-> prdata[31:16] == 16'h0000)
        else $error("pin state upper half not zero");
    a_pin_level: assert property (sq_pin_rd |-> prdata[15:0] == aux_pins_in)
        else $error("pin state differs from pins");
    a_rsvd_err: assert property (acc && (paddr == 8'h04 || paddr > 8'h1c) |-> pslverr && pready)
        else $error("unmapped access not refused");
    a_irq_en: assert property (irq |-> ien_q != 8'h00)
        else $error("interrupt without enable");
    a_irq_rise: assert property (sq_edge ##1 (!psel)[*4] |-> irq)
        else $error("enabled pin change gave no interrupt");
    a_read_clear: assert property (sq_pin_rd |=> !irq)
        else $error("pin state read left interrupt");
endmodule
bind sgp_gpio sgp_gpio_properties chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .aux_pins_in, .aux_pins_out, .aux_pins_oe_n, .irq);
`default_nettype wire

// ==== sim/sgp_board.sv ====
`timescale 1ns/10ps
`default_nettype none
module sgp_board (
    input  wire logic [15:0] out,    // device drive values
    input  wire logic [15:0] oe_n,   // low while device drives
    input  wire logic [15:0] ext,    // board drive values
    input  wire logic [15:0] ext_en, // board drives pin
    output var  logic [15:0] lvl     // resolved levels
);
    // undriven pins go to the pull-up, never a stale value
    assign lvl = (~oe_n & out) | (oe_n & ~ext_en) | (oe_n & ext_en & ext);
endmodule
`default_nettype wire

// ==== sim/sgp_gpio_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module sgp_gpio_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [7:0]  paddr, m_ien, m_sts;
    logic [31:0] pwdata, prdata, r, v;
    logic [15:0] lvl, pout, poe_n, ext, ext_en, m_dir, m_out, m_mask, m_lvl;
    logic [1:0]  m_ena;
    int          fail_count, check_count, seed;
    sgp_gpio dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .aux_pins_in(lvl), .aux_pins_out(pout), .aux_pins_oe_n(poe_n), .irq);
    sgp_board board_u (.out(pout), .oe_n(poe_n), .ext, .ext_en, .lvl);
    ////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        summarize;
    end
    task automatic summarize;
        if (fail_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // pready is polled, never assumed; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        chk({31'h0, e}, {31'h0, a == 8'h04 || a > 8'h1c});
    endtask
    task automatic settle(input logic live);
        logic [15:0] lv;
        repeat (6) @(posedge pclk);
        lv = (m_dir & m_out) | (~m_dir & (~ext_en | ext));
        if (live) m_sts = m_sts | (lv[15:8] ^ m_lvl[15:8]);
        m_lvl = lv;
        chk({16'h0, poe_n}, {16'h0, ~m_dir});
        chk({16'h0, pout}, {16'h0, m_out});
        chk({31'h0, irq}, {31'h0, |(m_sts & m_ien)});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic live;
        live = m_ena == 2'h1;
        apb(1'b1, a, d);
        if (a == 8'h14) m_ena = d[1:0];
        if (live && a == 8'h00) m_dir = d[15:0];
        if (live && a == 8'h08) m_out = (m_out & ~d[31:16]) | (d[15:0] & d[31:16]);
        if (live && a == 8'h08) m_mask = d[31:16];
        if (live && a == 8'h10) m_ien = d[7:0];
        if (a == 8'h1c) m_sts = m_sts & ~d[7:0];
        if (m_ena[1]) {m_dir, m_out, m_mask, m_ien, m_sts} = '0;
        settle(live && m_ena == 2'h1);
    endtask
    task automatic rd(input logic [7:0] a);
        logic [31:0] x;
        case (a)
            8'h00: x = {16'h0, m_dir};
            8'h08: x = {m_mask, m_out};
            8'h0c: x = m_ena[1] ? 32'h0 : {16'h0, m_lvl};
            8'h10: x = {24'h0, m_ien};
            8'h14: x = {30'h0, m_ena};
            8'h18: x = {24'h0, m_sts};
            default: x = 32'h0;
        endcase
        apb(1'b0, a, 32'h0);
        chk(r, x);
        if (a == 8'h0c) m_sts = 8'h00;
        settle(m_ena == 2'h1);
    endtask
    task automatic do_reset;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        {m_dir, m_out, m_mask, m_ien, m_sts, m_ena} = {80'h0, 2'h2};
        settle(1'b0);
    endtask
    ////////////////////////////////
    initial begin
        seed = 32'hed87;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        ext = 16'h5a3c;
        ext_en = 16'hfeff;
        @(posedge pclk);
        do_reset;
        for (int a = 0; a <= 32; a += 4) rd(a[7:0]);
        wr(8'h00, 32'h0000_ffff);
        wr(8'h14, 32'h0000_0000);
        wr(8'h00, 32'h0000_ffff);
        rd(8'h00);
        wr(8'h14, 32'h0000_0001);
        wr(8'h10, 32'h0000_00ff);
        // pin 8 has only the pull-up, so toggling its enable makes open drain
        wr(8'h08, 32'h0100_0000);
        wr(8'h00, 32'h0000_0100);
        rd(8'h18);
        wr(8'h00, 32'h0000_0000);
        rd(8'h0c);
        repeat (40) begin
            v = $random(seed);
            case (v[1:0])
                2'd0: wr(8'h00, {16'h0, v[31:16]});
                2'd1: wr(8'h08, $random(seed));
                2'd2: wr(8'h10, {24'h0, v[23:16]});
                default: begin
                    ext <= v[31:16];
                    ext_en <= v[15:0];
                    settle(1'b1);
                end
            endcase
            rd(8'h18);
            if (v[2])
                rd(8'h0c);
            else
                wr(8'h1c, {24'h0, v[15:8]});
        end
        wr(8'h14, 32'h0000_0003);
        rd(8'h08);
        do_reset;
        rd(8'h14);
        summarize;
    end
endmodule
`default_nettype wire
